// File: logic/sat_cfg.svh
// constants of the async serial transmitter block
`ifndef SAT_CFG_SVH
`define SAT_CFG_SVH

// ----------------------------------------------------------------
// configuration and timing
// ----------------------------------------------------------------
`define SAT_SYS_CONFIG_TWO_ADDR 16'h001e
`define SAT_CLK_HZ              100000000
`define SAT_RT_PER_BIT          16
`define SAT_RT_LAST             (4'(`SAT_RT_PER_BIT - 1))
`define SAT_RX_SAMPLE           4'h7
`define SAT_LAST_8              4'h9
`define SAT_LAST_9              4'ha
`define SAT_PRE_0               12'h001
`define SAT_PRE_1               12'h003
`define SAT_PRE_2               12'h004
`define SAT_PRE_3               12'h00d

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SAT_RST_EMPTY           1'b1
`define SAT_RST_DONE            1'b1
`define SAT_RST_PIN             1'b1

`endif

// File: logic/sat_pkg.sv
// types of the async serial transmitter block
`default_nettype none
package sat_pkg;
    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_READY = 2'b01,
        ST_SHIFT = 2'b10
    } sat_tx_st_t;
    typedef enum logic [1:0] {
        K_IDLE  = 2'b00,
        K_DATA  = 2'b01,
        K_BREAK = 2'b10,
        K_MARK  = 2'b11
    } sat_kind_t;
    typedef enum logic {
        RX_IDLE = 1'b0,
        RX_RUN  = 1'b1
    } sat_rx_st_t;
    typedef struct packed {
        logic       module_enable;
        logic       transmitter_enable;
        logic       rx_enable;
        logic       char_len9;
        logic       ninth_tx_bit;
        logic       send_break_bit;
        logic       tx_invert_bit;
        logic       tx_empty_irq_enable;
        logic       tx_complete_irq_enable;
        logic       baud_source_select;
        logic [4:0] baud_rate_sel;
    } sat_ctrl_t;
    typedef struct packed {
        logic [7:0] rx_data;
        logic       ninth_rx_bit;
        logic       framing_error_flag;
        logic       rx_full_flag;
        logic       break_flag;
    } sat_rx_status_t;
    typedef struct packed {
        logic [11:0] cnt;
        logic        tick;
    } sat_baud_state_t;
    typedef struct packed {
        sat_rx_st_t     st;
        logic [3:0]     rt;
        logic [3:0]     bitn;
        logic [8:0]     shreg;
        logic           prev;
        sat_rx_status_t stat;
    } sat_rx_state_t;
    typedef struct packed {
        sat_tx_st_t  st;
        sat_kind_t   kind;
        logic [3:0]  rt;
        logic [3:0]  bitn;
        logic [3:0]  last;
        logic [10:0] shreg;
        logic [7:0]  buffer;
        logic        empty;
        logic        armed;
        logic        te_prev;
        logic        idle_q;
        logic        done;
        logic        pin;
        logic        oe;
        logic        irq;
    } sat_tx_state_t;
endpackage : sat_pkg
`default_nettype wire

// File: logic/sat_baud.sv
// shared baud and sample reference clock generator
`timescale 1ns/1ns
`default_nettype none
`include "sat_cfg.svh"
module sat_baud
    import sat_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       enable_i,
    input  wire logic       source_i,
    input  wire logic [4:0] rate_i,
    output logic            rt_tick_o
);
    sat_baud_state_t s_reg;
    sat_baud_state_t s_next;

    // 4 prescales x 8 binary divisors, source doubles the period
    function automatic logic [11:0] sat_limit(input logic       src,
                                              input logic [4:0] r);
        logic [11:0] pre;
        unique case (r[4:3])
            2'h0: pre = `SAT_PRE_0;
            2'h1: pre = `SAT_PRE_1;
            2'h2: pre = `SAT_PRE_2;
            2'h3: pre = `SAT_PRE_3;
        endcase
        sat_limit = ((pre << r[2:0]) << src) - 12'h001;
    endfunction : sat_limit

    always_comb
    begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        if (!enable_i)
        begin
            s_next.cnt = 12'h000;
        end
        else if (s_reg.cnt >= sat_limit(source_i, rate_i))
        begin
            s_next.cnt  = 12'h000;
            s_next.tick = 1'b1;
        end
        else
        begin
            s_next.cnt = s_reg.cnt + 12'h001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign rt_tick_o = s_reg.tick;
endmodule : sat_baud
`default_nettype wire

// File: logic/sat_brk_rx.sv
// receiver framing and break detection
`timescale 1ns/1ns
`default_nettype none
`include "sat_cfg.svh"
module sat_brk_rx
    import sat_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     reset_i,
    input  wire logic     enable_i,
    input  wire logic     char_len9_i,
    input  wire logic     rt_tick_i,
    input  wire logic     rx_pin_i,
    input  wire logic     flags_clear_i,
    output sat_rx_status_t status_o
);
    sat_rx_state_t s_reg;
    sat_rx_state_t s_next;
    logic [3:0]    last;
    logic          zeros;

    always_comb
    begin
        s_next = s_reg;
        last   = char_len9_i ? `SAT_LAST_9 : `SAT_LAST_8;
        zeros  = char_len9_i ? (s_reg.shreg == 9'h000)
                             : (s_reg.shreg[7:0] == 8'h00);
        if (flags_clear_i)
        begin
            s_next.stat.framing_error_flag = 1'b0;
            s_next.stat.rx_full_flag       = 1'b0;
            s_next.stat.break_flag         = 1'b0;
        end
        if (!enable_i)
        begin
            s_next.st = RX_IDLE;
        end
        else if (rt_tick_i)
        begin
            s_next.prev = rx_pin_i;
            unique case (s_reg.st)
                RX_IDLE:
                begin
                    if (s_reg.prev && !rx_pin_i)
                    begin
                        s_next.st    = RX_RUN;
                        s_next.rt    = 4'h0;
                        s_next.bitn  = 4'h0;
                        s_next.shreg = 9'h000;
                    end
                end
                RX_RUN:
                begin
                    s_next.rt = s_reg.rt + 4'h1;
                    if (s_reg.rt == `SAT_RX_SAMPLE)
                    begin
                        s_next.bitn = s_reg.bitn + 4'h1;
                        if (s_reg.bitn == 4'h0 && rx_pin_i)
                            s_next.st = RX_IDLE;
                        else if (s_reg.bitn == last)
                        begin
                            s_next.st                      = RX_IDLE;
                            s_next.stat.rx_full_flag       = 1'b1;
                            s_next.stat.framing_error_flag = !rx_pin_i;
                            if (!rx_pin_i && zeros)
                            begin
                                s_next.stat.break_flag   = 1'b1;
                                s_next.stat.rx_data      = 8'h00;
                                s_next.stat.ninth_rx_bit = 1'b0;
                            end
                            else
                            begin
                                s_next.stat.rx_data      = s_reg.shreg[7:0];
                                s_next.stat.ninth_rx_bit = char_len9_i
                                    ? s_reg.shreg[8] : s_reg.shreg[7];
                            end
                        end
                        else if (s_reg.bitn != 4'h0)
                            s_next.shreg[s_reg.bitn - 4'h1] = rx_pin_i;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            s_reg      <= '0;
            s_reg.prev <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    assign status_o = s_reg.stat;

    property p_break_flags;
        @(posedge clk_i) disable iff (reset_i)
        $rose(s_reg.stat.break_flag) |-> s_reg.stat.framing_error_flag
            && s_reg.stat.rx_full_flag && s_reg.stat.rx_data == 8'h00
            && !s_reg.stat.ninth_rx_bit;
    endproperty
    a_break_flags: assert property (p_break_flags)
        else $error("break did not set flags and clear data");
endmodule : sat_brk_rx
`default_nettype wire

// File: logic/sat_tx.sv
// async serial transmitter top with break receiver
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "sat_cfg.svh"
module sat_tx
    import sat_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire sat_ctrl_t  ctrl_i,
    input  wire logic       serial_status_one_read_i,
    input  wire logic       serial_data_buffer_write_i,
    input  wire logic [7:0] serial_data_buffer_i,
    input  wire logic       rx_pin_i,
    input  wire logic       rx_flags_clear_i,
    output logic            tx_pin_o,
    output logic            tx_pin_oe_o,
    output logic            tx_empty_flag_o,
    output logic            tx_complete_flag_o,
    output logic            tx_irq_o,
    output sat_rx_status_t  rx_status_o
);
    sat_tx_state_t s_reg;
    sat_tx_state_t s_next;
    logic          rt_tick;
    logic          char_end;
    logic          te_rise;
    logic          decide;
    logic          load_data;
    logic [3:0]    last_now;

    // ------------------------------------------------------------
    // frame patterns, shifted out from bit 0
    // ------------------------------------------------------------
    function automatic logic [10:0] sat_frame(input sat_kind_t  k,
                                              input logic [7:0] d,
                                              input logic       b8,
                                              input logic       m);
        unique case (k)
            K_IDLE:  sat_frame = 11'h7ff;
            K_MARK:  sat_frame = 11'h7ff;
            K_BREAK: sat_frame = 11'h000;
            K_DATA:  sat_frame = {1'b1, m ? b8 : 1'b1, d, 1'b0};
        endcase
    endfunction : sat_frame

    // ------------------------------------------------------------
    // shared rate generator and receiver
    // ------------------------------------------------------------
    sat_baud u_baud (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .enable_i  (ctrl_i.module_enable),
        .source_i  (ctrl_i.baud_source_select),
        .rate_i    (ctrl_i.baud_rate_sel),
        .rt_tick_o (rt_tick)
    );

    sat_brk_rx u_rx (
        .clk_i         (clk_i),
        .reset_i       (reset_i),
        .enable_i      (ctrl_i.module_enable && ctrl_i.rx_enable),
        .char_len9_i   (ctrl_i.char_len9),
        .rt_tick_i     (rt_tick),
        .rx_pin_i      (rx_pin_i),
        .flags_clear_i (rx_flags_clear_i),
        .status_o      (rx_status_o)
    );

    // ------------------------------------------------------------
    // transmitter next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_next    = s_reg;
        load_data = 1'b0;
        last_now  = ctrl_i.char_len9 ? `SAT_LAST_9 : `SAT_LAST_8;
        te_rise   = ctrl_i.transmitter_enable && !s_reg.te_prev;
        char_end  = s_reg.st == ST_SHIFT && rt_tick
                    && s_reg.rt == `SAT_RT_LAST
                    && s_reg.bitn == s_reg.last;
        decide    = char_end || s_reg.st == ST_READY;
        s_next.te_prev = ctrl_i.transmitter_enable;

        // status read arms, data write clears the empty flag
        if (serial_status_one_read_i && s_reg.empty)
            s_next.armed = 1'b1;
        if (serial_data_buffer_write_i)
        begin
            s_next.buffer = serial_data_buffer_i;
            if (s_reg.armed)
            begin
                s_next.empty = 1'b0;
                s_next.armed = 1'b0;
            end
        end

        if (te_rise && s_reg.st == ST_SHIFT)
            s_next.idle_q = 1'b1;

        // bit timing
        if (s_reg.st == ST_SHIFT && rt_tick)
        begin
            s_next.rt = s_reg.rt + 4'h1;
            if (s_reg.rt == `SAT_RT_LAST && s_reg.bitn != s_reg.last)
            begin
                s_next.bitn  = s_reg.bitn + 4'h1;
                s_next.shreg = {s_reg.kind != K_BREAK,
                                s_reg.shreg[10:1]};
            end
        end

        if (!ctrl_i.module_enable)
        begin
            s_next.st     = ST_OFF;
            s_next.idle_q = 1'b0;
        end
        else if (s_reg.st == ST_OFF)
        begin
            if (ctrl_i.transmitter_enable)
            begin
                s_next.st    = ST_SHIFT;
                s_next.kind  = K_IDLE;
                s_next.rt    = 4'h0;
                s_next.bitn  = 4'h0;
                s_next.last  = last_now;
                s_next.shreg = sat_frame(K_IDLE, 8'h00, 1'b0, 1'b0);
            end
        end
        else if (decide)
        begin
            s_next.rt   = 4'h0;
            s_next.bitn = 4'h0;
            s_next.last = last_now;
            if (char_end && s_reg.kind == K_BREAK
                && !ctrl_i.send_break_bit)
            begin
                s_next.st    = ST_SHIFT;
                s_next.kind  = K_MARK;
                s_next.last  = 4'h0;
                s_next.shreg = sat_frame(K_MARK, 8'h00, 1'b0, 1'b0);
            end
            else if (!ctrl_i.transmitter_enable)
            begin
                s_next.st     = ST_OFF;
                s_next.idle_q = 1'b0;
                if (!s_reg.empty)
                    s_next.empty = 1'b1;
            end
            else if (ctrl_i.send_break_bit)
            begin
                s_next.st    = ST_SHIFT;
                s_next.kind  = K_BREAK;
                s_next.shreg = sat_frame(K_BREAK, 8'h00, 1'b0, 1'b0);
            end
            else if (s_reg.idle_q || te_rise)
            begin
                s_next.st     = ST_SHIFT;
                s_next.kind   = K_IDLE;
                s_next.idle_q = 1'b0;
                s_next.shreg  = sat_frame(K_IDLE, 8'h00, 1'b0, 1'b0);
            end
            else if (!s_reg.empty)
            begin
                load_data    = 1'b1;
                s_next.st    = ST_SHIFT;
                s_next.kind  = K_DATA;
                s_next.empty = 1'b1;
                s_next.armed = 1'b0;
                s_next.shreg = sat_frame(K_DATA, s_reg.buffer,
                                         ctrl_i.ninth_tx_bit,
                                         ctrl_i.char_len9);
            end
            else
            begin
                s_next.st = ST_READY;
            end
        end

        // outputs, all registered
        s_next.done = s_next.st != ST_SHIFT && s_next.empty
                      && !s_next.idle_q
                      && !ctrl_i.send_break_bit;
        s_next.pin  = ctrl_i.tx_invert_bit
                      ^ (s_next.st == ST_SHIFT ? s_next.shreg[0]
                                               : 1'b1);
        s_next.oe   = ctrl_i.module_enable;
        s_next.irq  = (s_reg.empty && ctrl_i.tx_empty_irq_enable)
                      || (s_reg.done
                          && ctrl_i.tx_complete_irq_enable);
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            s_reg       <= '0;
            s_reg.empty <= `SAT_RST_EMPTY;
            s_reg.done  <= `SAT_RST_DONE;
            s_reg.pin   <= `SAT_RST_PIN;
        end
        else
            s_reg <= s_next;
    end

    assign tx_pin_o           = s_reg.pin;
    assign tx_pin_oe_o        = s_reg.oe;
    assign tx_empty_flag_o    = s_reg.empty;
    assign tx_complete_flag_o = s_reg.done;
    assign tx_irq_o           = s_reg.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_idle_level;
        @(posedge clk_i) disable iff (reset_i)
        (!$past(reset_i) && s_reg.st != ST_SHIFT)
            |-> tx_pin_o == !$past(ctrl_i.tx_invert_bit);
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("line not idle while no character shifts");

    property p_irq;
        @(posedge clk_i) disable iff (reset_i)
        !$past(reset_i) |-> tx_irq_o ==
            (($past(tx_empty_flag_o) && $past(ctrl_i.tx_empty_irq_enable))
            || ($past(tx_complete_flag_o)
                && $past(ctrl_i.tx_complete_irq_enable)));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow flags and enables");

    property p_empty_clear;
        @(posedge clk_i) disable iff (reset_i)
        $fell(tx_empty_flag_o)
            |-> $past(serial_data_buffer_write_i) && $past(s_reg.armed);
    endproperty
    a_empty_clear: assert property (p_empty_clear)
        else $error("empty flag cleared without read and write");

    property p_empty_set;
        @(posedge clk_i) disable iff (reset_i)
        load_data |=> tx_empty_flag_o && s_reg.kind == K_DATA;
    endproperty
    a_empty_set: assert property (p_empty_set)
        else $error("empty flag not set on hand-off");

    property p_bit_time;
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.st == ST_SHIFT && $past(s_reg.st) == ST_SHIFT
            && $changed(s_reg.shreg))
            |-> $past(rt_tick) && $past(s_reg.rt) == `SAT_RT_LAST;
    endproperty
    a_bit_time: assert property (p_bit_time)
        else $error("bit changed before sixteen sample clocks");

    property p_break_zero;
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.st == ST_SHIFT && s_reg.kind == K_BREAK)
            |-> s_reg.shreg == 11'h000;
    endproperty
    a_break_zero: assert property (p_break_zero)
        else $error("break character holds a one");

    property p_preamble;
        @(posedge clk_i) disable iff (reset_i)
        ($past(s_reg.st) == ST_OFF && s_reg.st == ST_SHIFT)
            |-> s_reg.kind == K_IDLE && s_reg.shreg == 11'h7ff;
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("transmission did not open with a preamble");

    property p_frame;
        @(posedge clk_i) disable iff (reset_i)
        $past(load_data) |-> !s_reg.shreg[0] && s_reg.shreg[s_reg.last];
    endproperty
    a_frame: assert property (p_frame)
        else $error("data character lacks start or stop bit");

    property p_break_tail;
        @(posedge clk_i) disable iff (reset_i)
        (char_end && s_reg.kind == K_BREAK && !ctrl_i.send_break_bit
            && ctrl_i.module_enable)
            |=> s_reg.st == ST_SHIFT && s_reg.kind == K_MARK
                && tx_pin_o == !$past(ctrl_i.tx_invert_bit);
    endproperty
    a_break_tail: assert property (p_break_tail)
        else $error("no mark bit after the last break");

    property p_pin_release;
        @(posedge clk_i) disable iff (reset_i)
        !$past(reset_i) |-> tx_pin_oe_o == $past(ctrl_i.module_enable);
    endproperty
    a_pin_release: assert property (p_pin_release)
        else $error("pin ownership does not follow module enable");
endmodule : sat_tx
`default_nettype wire

// File: tb/sat_far_end.sv
// far-end receiver model for the transmit line
`timescale 1ns/1ns
`default_nettype none
module sat_far_end
(
    input  wire logic  clk_i,
    input  wire logic  line_i,
    output logic       echo_o,
    output logic [7:0] byte_o,
    output logic       stop_o,
    output logic       got_o
);
    int         c = 0;
    logic [8:0] sh;
    logic       prev = 1'b1;
    initial got_o = 1'b0;
    // loop back so the block's receiver hears its own frames
    assign echo_o = line_i;
    always @(posedge clk_i)
    begin
        got_o <= 1'b0;
        prev  <= line_i;
        // a start needs a falling edge, not a low tail of a frame
        if (c == 0 && prev && line_i == 1'b0)
            c <= 1;
        else if (c > 0)
        begin
            c <= c + 1;
            // mid-bit samples, lsb first, 16 cycles a bit
            if (c % 16 == 8 && c > 8 && c < 152)
                sh <= {line_i, sh[8:1]};
            if (c == 152)
            begin
                byte_o <= sh[8:1];
                stop_o <= line_i;
                got_o  <= 1'b1;
                c      <= 0;
            end
        end
    end
endmodule : sat_far_end
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the async serial transmitter
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sat_pkg::*;
    logic           clk = 1'b0;
    logic           reset = 1'b1;
    logic           rd = 1'b0;
    logic           wr = 1'b0;
    logic [7:0]     din = 8'h00;
    sat_ctrl_t      ctrl = '0;
    sat_rx_status_t rxs;
    logic [7:0]     rbyte;
    logic [7:0]     b;
    logic           pin, oe, empty, cmpl, irq, line, echo, stop, got;
    int             errors = 0;
    int             samples_checked = 0;
    logic [31:0]    seed = 32'h00000041;
    initial forever #5 clk = ~clk;
    assign line = oe ? pin : 1'b1;
    sat_tx dut (.clk_i(clk), .reset_i(reset), .ctrl_i(ctrl),
        .serial_status_one_read_i(rd), .serial_data_buffer_write_i(wr),
        .serial_data_buffer_i(din), .rx_pin_i(echo),
        .rx_flags_clear_i(1'b0), .tx_pin_o(pin), .tx_pin_oe_o(oe),
        .tx_empty_flag_o(empty), .tx_complete_flag_o(cmpl),
        .tx_irq_o(irq), .rx_status_o(rxs));
    sat_far_end far (.clk_i(clk), .line_i(line), .echo_o(echo),
        .byte_o(rbyte), .stop_o(stop), .got_o(got));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report;
        if (errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic send(input logic [7:0] d);
        @(posedge clk) rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        wr  <= 1'b1;
        din <= d;
        @(posedge clk) wr <= 1'b0;
    endtask : send
    task automatic expect_byte(input logic [8:0] e);
        int n;
        n = 0;
        while (got !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        chk({stop, rbyte}, e);
        @(posedge clk);
    endtask : expect_byte
    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        ctrl.module_enable <= 1'b1;
        ctrl.rx_enable <= 1'b1;
        ctrl.tx_empty_irq_enable <= 1'b1;
        @(posedge clk) ctrl.transmitter_enable <= 1'b1;
        // write with no status read first
        @(posedge clk) wr <= 1'b1;
        din <= 8'h3c;
        @(posedge clk) wr <= 1'b0;
        @(negedge clk) chk(empty, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
            // change length only while the line is quiet
            while ((i == 2) != ctrl.char_len9 && cmpl !== 1'b1)
                @(posedge clk);
            ctrl.char_len9 <= (i == 2);
            if (i == 5)
            begin
                ctrl.transmitter_enable <= 1'b0;
                @(posedge clk) ctrl.transmitter_enable <= 1'b1;
            end
            send(b);
            @(negedge clk) chk(pin, 1'b1);
            if (i == 5)
            begin
                repeat (10) @(posedge clk);
                @(negedge clk) chk(pin, 1'b1);
            end
            if (i == 0)
                chk(empty, 1'b0);
            expect_byte({i != 2, b});
            chk(rxs.break_flag, 1'b0);
        end
        ctrl.send_break_bit <= 1'b1;
        repeat (400) @(posedge clk);
        ctrl.send_break_bit <= 1'b0;
        repeat (400) @(posedge clk);
        @(negedge clk) chk({rxs.break_flag, rxs.framing_error_flag}, 2'h3);
        chk(rxs.rx_data, 8'h00);
        chk(pin, 1'b1);
        send(8'ha5);
        expect_byte({1'b1, 8'ha5});
        repeat (40) @(posedge clk);
        @(negedge clk) chk({irq, cmpl, pin}, 3'h7);
        @(posedge clk) ctrl.tx_empty_irq_enable <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk) chk(irq, 1'b0);
        @(posedge clk) ctrl.module_enable <= 1'b0;
        ctrl.tx_invert_bit <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk) chk(oe, 1'b0);
        chk(pin, 1'b0);
        final_report();
    end
    initial
    begin
        #100000;
        errors++;
        final_report();
    end
endmodule : testbench
`default_nettype wire
